// ---- verilog/pat_arbiter.sv ----
// top: user address table, matcher, transmit buffer and packet link
// assumes the host holds SPI_SS_N_I low a few CLOCK_I cycles before its first edge
`timescale 1ns/1ps
module pat_arbiter
  import pat_pkg::*;
(
  // core clock and reset
  input  wire logic                CLOCK_I,
  input  wire logic                RST_I,
  // link from the host
  input  wire logic                SPI_SCK_I,
  input  wire logic                SPI_SS_N_I,
  input  wire logic                SPI_MOSI_I,
  output logic                     SPI_MISO_O,
  // packet sources inside the decoder
  input  wire logic                CHECKSUM_DIS_I,
  input  wire logic [PKT_W-1:0]    PART_ID_WORD_I,
  input  wire logic [PKT_W-1:0]    STATUS_WORD_I,
  input  wire logic                SHUTDOWN_REQ_I,
  input  wire logic [PKT_W-1:0]    SHUTDOWN_WORD_I,
  input  wire logic                ROAM_REQ_I,
  input  wire logic [PKT_W-1:0]    ROAM_WORD_I,
  input  wire logic                DATA_VALID_I,
  input  wire logic [PKT_W-1:0]    DATA_WORD_I,
  input  wire logic                DECODE_RESTART_I,
  // received address word from the radio path
  input  wire logic                RX_ADDR_VALID_I,
  input  wire logic [ADDR_W-1:0]   RX_ADDR_I,
  input  wire logic [1:0]          RX_ADDR_ERRS_I,
  // results
  output logic [MASK_W-1:0]        ENABLE_MASK_O,
  output logic                     MATCH_VALID_O,
  output logic [WIDX_W-1:0]        MATCH_INDEX_O,
  output logic                     SKIP_VECTOR_O,
  output logic                     DECODE_STOP_O,
  output logic [BCNT_W-1:0]        BUF_LEVEL_O
);

  // link domain state
  logic [BIT_CNT_W-1:0] bit_cnt_ff;
  logic [PKT_W-1:0]     rx_shift_ff;
  logic [PKT_W-1:0]     rx_word_ff;
  logic                 xfer_tgl_ff;
  logic [PKT_W-1:0]     tx_shift_ff;
  logic                 miso_ff;

  // core domain state
  logic [2:0]           ss_sync_ff;
  logic [2:0]           tgl_sync_ff;
  logic                 tgl_seen_ff;
  logic                 ss_idle_ff;
  logic [PKT_W-1:0]     tx_word_ff;
  pat_src_e             tx_src_ff;
  logic                 shut_pend_ff;
  logic [PKT_W-1:0]     shut_word_ff;
  logic                 roam_pend_ff;
  logic [PKT_W-1:0]     roam_word_ff;
  logic [MASK_W-1:0]    word_enable_bit_ff;
  pat_word_s            table_ff [NUM_WORDS];
  logic [PKT_W-1:0]     buf_ff [BUF_DEPTH];
  logic [BPTR_W-1:0]    wr_ptr_ff;
  logic [BPTR_W-1:0]    rd_ptr_ff;
  logic [BCNT_W-1:0]    buf_cnt_ff;
  logic                 stop_ff;
  logic                 match_valid_ff;
  logic [WIDX_W-1:0]    matched_index_ff;
  logic                 skip_ff;

  // combinational helpers
  logic                 xfer_done;
  logic [PKT_W-1:0]     rx_pkt;
  logic                 hit;
  logic [WIDX_W-1:0]    hit_idx;
  logic                 push;
  logic [PKT_W-1:0]     push_word;
  logic                 pop;
  logic                 overflow;
  pat_src_e             nxt_src;
  logic [PKT_W-1:0]     nxt_word;

  // bit counter restarts whenever the frame select is released
  always_ff @(posedge SPI_SCK_I or posedge SPI_SS_N_I) begin
    if (SPI_SS_N_I) begin
      bit_cnt_ff <= '0;
    end else begin
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
    end
  end

  // receive shift, host data sampled on the rising edge
  always_ff @(posedge SPI_SCK_I) begin
    rx_shift_ff <= {rx_shift_ff[PKT_W-2:0], SPI_MOSI_I};
  end

  // completed packet is held until the next one ends, long enough for the core to read it;
  // RST_I clears it while the link clock is parked, so the toggle never starts unknown
  always_ff @(posedge SPI_SCK_I or posedge RST_I) begin
    if (RST_I) begin
      rx_word_ff  <= '0;
      xfer_tgl_ff <= 1'b0;
    end else if (!SPI_SS_N_I && bit_cnt_ff == BIT_LAST) begin
      rx_word_ff  <= {rx_shift_ff[PKT_W-2:0], SPI_MOSI_I};
      xfer_tgl_ff <= ~xfer_tgl_ff;
    end
  end

  // transmit shift; tx_word_ff is frozen by the core while a frame is open
  always_ff @(posedge SPI_SCK_I) begin
    if (bit_cnt_ff == '0) begin
      tx_shift_ff <= {tx_word_ff[PKT_W-2:0], 1'b0};
      miso_ff     <= tx_word_ff[ID_MSB];
    end else begin
      tx_shift_ff <= {tx_shift_ff[PKT_W-2:0], 1'b0};
      miso_ff     <= tx_shift_ff[PKT_W-1];
    end
  end

  // three-stage synchronisers into the core domain
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      ss_sync_ff  <= 3'h7;
      tgl_sync_ff <= 3'h0;
    end else begin
      ss_sync_ff  <= {ss_sync_ff[1:0], SPI_SS_N_I};
      tgl_sync_ff <= {tgl_sync_ff[1:0], xfer_tgl_ff};
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      tgl_seen_ff <= 1'b0;
      ss_idle_ff  <= 1'b1;
    end else begin
      if (xfer_done) begin
        tgl_seen_ff <= tgl_sync_ff[2];
      end
      if (ss_sync_ff[1] == ss_sync_ff[2]) begin
        ss_idle_ff <= ss_sync_ff[2];
      end
    end
  end

  assign xfer_done = (tgl_sync_ff[1] == tgl_sync_ff[2]) && (tgl_sync_ff[2] != tgl_seen_ff);
  assign rx_pkt    = rx_word_ff;

  // enable mask, applied at once even while decoding runs
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      word_enable_bit_ff <= MASK_RST;
    end else if (xfer_done && rx_pkt[ID_MSB:ID_LSB] == ID_ENABLE_MASK) begin
      word_enable_bit_ff <= rx_pkt[MASK_W-1:0];
    end
  end

  // assignment table; the host clears the enable before rewriting, so no match sees a half word
  always_ff @(posedge CLOCK_I) begin
    if (xfer_done && rx_pkt[ID_MSB:ID_MSB-3] == ID_ASSIGN_HI) begin
      table_ff[rx_pkt[IDX_LSB+WIDX_W-1:IDX_LSB]] <= '{long_flag:      rx_pkt[LONG_BIT],
                                                      tone_only_flag: rx_pkt[TONE_BIT],
                                                      addr:           rx_pkt[ADDR_W-1:0]};
    end
  end

  // matcher: lowest enabled equal word wins
  always_comb begin
    hit     = 1'b0;
    hit_idx = '0;
    for (int i = NUM_WORDS-1; i >= 0; i--) begin
      if (word_enable_bit_ff[i] && table_ff[i].addr == RX_ADDR_I) begin
        hit     = 1'b1;
        hit_idx = WIDX_W'(i);
      end
    end
    hit = hit && RX_ADDR_VALID_I && (RX_ADDR_ERRS_I < ERR_LIMIT) && !stop_ff;
  end

  // match result and vector skip for tone-only words
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      match_valid_ff   <= 1'b0;
      matched_index_ff <= '0;
      skip_ff          <= 1'b0;
    end else begin
      match_valid_ff <= hit;
      skip_ff        <= hit && table_ff[hit_idx].tone_only_flag;
      if (hit) begin
        matched_index_ff <= hit_idx;
      end
    end
  end

  // address report has priority over other data in the same cycle
  always_comb begin
    push_word = DATA_WORD_I;
    if (hit) begin
      push_word = '0;
      push_word[ID_MSB:ID_LSB] = ID_ADDR_REPORT;
      push_word[REP_LONG_BIT]  = table_ff[hit_idx].long_flag;
      push_word[REP_IDX_LSB+7:REP_IDX_LSB] = {4'h0, hit_idx};
    end
  end

  assign push     = hit || (DATA_VALID_I && !stop_ff);
  assign pop      = xfer_done && tx_src_ff == SRC_BUFFER && buf_cnt_ff != '0; // overflow may empty it mid-frame
  assign overflow = push && !pop && buf_cnt_ff == BUF_FULL;

  // transmit buffer storage
  always_ff @(posedge CLOCK_I) begin
    if (push && !overflow) begin
      buf_ff[wr_ptr_ff] <= push_word;
    end
  end

  // buffer pointers; an overflow empties it
  always_ff @(posedge CLOCK_I) begin
    if (RST_I || overflow) begin
      wr_ptr_ff  <= '0;
      rd_ptr_ff  <= '0;
      buf_cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 5'h01;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 5'h01;
      end
      buf_cnt_ff <= buf_cnt_ff + BCNT_W'(push) - BCNT_W'(pop);
    end
  end

  // decoding stop after overflow; a new overflow beats a restart
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      stop_ff <= 1'b0;
    end else if (overflow) begin
      stop_ff <= 1'b1;
    end else if (DECODE_RESTART_I) begin
      stop_ff <= 1'b0;
    end
  end

  // pending shutdown and roaming packets; a new request beats the clear by sending
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      shut_pend_ff <= 1'b0;
      roam_pend_ff <= 1'b0;
      shut_word_ff <= '0;
      roam_word_ff <= '0;
    end else begin
      if (SHUTDOWN_REQ_I) begin
        shut_pend_ff <= 1'b1;
        shut_word_ff <= SHUTDOWN_WORD_I;
      end else if (xfer_done && tx_src_ff == SRC_SHUTDOWN) begin
        shut_pend_ff <= 1'b0;
      end
      if (ROAM_REQ_I) begin
        roam_pend_ff <= 1'b1;
        roam_word_ff <= ROAM_WORD_I;
      end else if (xfer_done && tx_src_ff == SRC_ROAM) begin
        roam_pend_ff <= 1'b0;
      end
    end
  end

  // outbound selection
  always_comb begin
    if (CHECKSUM_DIS_I) begin
      nxt_src  = SRC_PART_ID;
      nxt_word = PART_ID_WORD_I;
    end else if (shut_pend_ff) begin
      nxt_src  = SRC_SHUTDOWN;
      nxt_word = shut_word_ff;
    end else if (roam_pend_ff) begin
      nxt_src  = SRC_ROAM;
      nxt_word = roam_word_ff;
    end else if (buf_cnt_ff != '0) begin
      nxt_src  = SRC_BUFFER;
      nxt_word = buf_ff[rd_ptr_ff];
    end else begin
      nxt_src  = SRC_STATUS;
      nxt_word = STATUS_WORD_I;
    end
  end

  // offered word only changes between frames, so the link side sees it steady
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      tx_word_ff <= '0;
      tx_src_ff  <= SRC_STATUS;
    end else if (ss_idle_ff && !xfer_done) begin
      tx_word_ff <= nxt_word;
      tx_src_ff  <= nxt_src;
    end
  end

  // outputs
  assign SPI_MISO_O    = miso_ff;
  assign ENABLE_MASK_O = word_enable_bit_ff;
  assign MATCH_VALID_O = match_valid_ff;
  assign MATCH_INDEX_O = matched_index_ff;
  assign SKIP_VECTOR_O = skip_ff;
  assign DECODE_STOP_O = stop_ff;
  assign BUF_LEVEL_O   = buf_cnt_ff;

endmodule

// ---- shared/pat_pkg.sv ----
// package: constants, packet layout and types for the pager address table block
// assumes 32-bit packets, byte 3 in bits 31..24, exchanged over a spi-style link
// Functional notes
// - id 120 carries sixteen word enable bits
// - set bit enables word, clear disables
// - bit 0 to id 128, bit 15 to 143
// - all enable bits zero after reset
// - packets accepted and applied while decoding runs
// - sixteen user address words are provided
// - ids 128..143 assign, low nibble picks word
// - word index zero reports as index zero
// - long flag, tone flag, 21-bit address layout
// - tone-only match skips the following vector
// - outbound packets shift msb first
// - checksum-disabled device sends part id only
// - data packets queue in 32-deep buffer
// - order: shutdown, roaming, buffer, then status
// - buffer overflow stops decoding, clears buffer
// - address report id 1, under three errors
// - report byte 1 carries matched index
package pat_pkg;

  // packet framing
  localparam int           PKT_W          = 32;
  localparam int           ID_MSB         = 31;
  localparam int           ID_LSB         = 24;
  localparam logic [7:0]   ID_ENABLE_MASK = 8'h78;   // 120
  localparam logic [3:0]   ID_ASSIGN_HI   = 4'h8;    // ids 128..143
  localparam logic [7:0]   ID_ADDR_REPORT = 8'h01;
  localparam int           IDX_LSB        = 24;
  localparam int           LONG_BIT       = 22;
  localparam int           TONE_BIT       = 21;
  localparam int           ADDR_W         = 21;
  localparam int           MASK_W         = 16;
  localparam logic [15:0]  MASK_RST       = 16'h0000;
  localparam int           REP_LONG_BIT   = 20;      // byte 2 bit 4 of the report
  localparam int           REP_IDX_LSB    = 8;
  localparam logic [1:0]   ERR_LIMIT      = 2'h3;    // fewer than three bit errors

  // table and buffer sizes
  localparam int           NUM_WORDS      = 16;
  localparam int           WIDX_W         = 4;
  localparam int           BUF_DEPTH      = 32;
  localparam int           BPTR_W         = 5;
  localparam int           BCNT_W         = 6;
  localparam logic [5:0]   BUF_FULL       = 6'h20;

  // link bit counter
  localparam int           BIT_CNT_W      = 5;
  localparam logic [4:0]   BIT_LAST       = 5'h1f;

  // one user address word
  typedef struct packed {
    logic              long_flag;
    logic              tone_only_flag;
    logic [ADDR_W-1:0] addr;
  } pat_word_s;

  // source of the packet offered to the link
  typedef enum logic [4:0] {
    SRC_PART_ID  = 5'b00001,
    SRC_SHUTDOWN = 5'b00010,
    SRC_ROAM     = 5'b00100,
    SRC_BUFFER   = 5'b01000,
    SRC_STATUS   = 5'b10000
  } pat_src_e;

endpackage

// ---- verif/pat_arbiter_props.sv ----
// checker: port-level assertions for the address table and packet arbiter
// assumes one core clock domain; bound into every pat_arbiter instance
`timescale 1ns/1ps
module pat_arbiter_props
  import pat_pkg::*;
(
  // clock, reset and inputs
  input wire logic              CLOCK_I,
  input wire logic              RST_I,
  input wire logic              RX_ADDR_VALID_I,
  input wire logic [1:0]        RX_ADDR_ERRS_I,
  input wire logic              DECODE_RESTART_I,
  // results
  input wire logic [MASK_W-1:0] ENABLE_MASK_O,
  input wire logic              MATCH_VALID_O,
  input wire logic [WIDX_W-1:0] MATCH_INDEX_O,
  input wire logic              SKIP_VECTOR_O,
  input wire logic              DECODE_STOP_O,
  input wire logic [BCNT_W-1:0] BUF_LEVEL_O
);
  logic [MASK_W-1:0] mask_ff;

  // mask as the matcher saw it on the request edge
  always_ff @(posedge CLOCK_I) begin
    mask_ff <= ENABLE_MASK_O;
  end

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  chk_mask_reset: assert property ($fell(RST_I) |-> ENABLE_MASK_O == MASK_RST)
    else $error("mask not clear after reset");
  chk_err_refused: assert property (RX_ADDR_VALID_I && RX_ADDR_ERRS_I == ERR_LIMIT |=> !MATCH_VALID_O)
    else $error("match despite three errors");
  chk_match_cause: assert property (MATCH_VALID_O |-> $past(RX_ADDR_VALID_I))
    else $error("match without a received word");
  chk_match_enabled: assert property (MATCH_VALID_O |-> mask_ff[MATCH_INDEX_O])
    else $error("match on a disabled word");
  chk_skip_match: assert property (SKIP_VECTOR_O |-> MATCH_VALID_O)
    else $error("vector skip without match");
  chk_level_cap: assert property (BUF_LEVEL_O <= BUF_FULL)
    else $error("buffer level above depth");
  chk_ovf_clear: assert property ($rose(DECODE_STOP_O) |-> ##[0:1] BUF_LEVEL_O == 6'h00)
    else $error("buffer kept after overflow");
  chk_stop_hold: assert property (DECODE_STOP_O && !DECODE_RESTART_I |=> DECODE_STOP_O)
    else $error("decode stop dropped alone");
  chk_stop_nomatch: assert property (DECODE_STOP_O && RX_ADDR_VALID_I |=> !MATCH_VALID_O)
    else $error("match while stopped");
endmodule

bind pat_arbiter pat_arbiter_props u_props (.CLOCK_I, .RST_I, .RX_ADDR_VALID_I, .RX_ADDR_ERRS_I,
  .DECODE_RESTART_I, .ENABLE_MASK_O, .MATCH_VALID_O, .MATCH_INDEX_O, .SKIP_VECTOR_O,
  .DECODE_STOP_O, .BUF_LEVEL_O);

// ---- verif/pat_host_model.sv ----
// partner: host controller as link master with a 15 ns link clock
// assumes the device shifts out on the rising edge; host samples on falling
`timescale 1ns/1ps
module pat_host_model
  import pat_pkg::*;
(
  // link pins
  output logic      sck_o,
  output logic      ss_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  // idle: clock parked low, select high
  initial begin
    sck_o = 1'h0;
    ss_n_o = 1'h1;
    mosi_o = 1'h0;
  end

  // one whole packet; the clock runs only inside the frame
  task automatic xfer(input logic [PKT_W-1:0] tx, output logic [PKT_W-1:0] rx);
    ss_n_o = 1'h0;
    #30;
    for (int i = PKT_W-1; i >= 0; i--) begin
      mosi_o = tx[i];
      #7.5 sck_o = 1'h1;
      #7.5 rx[i] = miso_i;
      sck_o = 1'h0;
    end
    #10 ss_n_o = 1'h1;
    mosi_o = ~mosi_o;      // released line must not look held
    #80;                   // long gap: the core crosses by toggle
  endtask
endmodule

// ---- verif/pat_arbiter_tb.sv ----
// bench: link packets, address hits and buffer traffic for pat_arbiter
// assumes the host model on the link and a 200 MHz core clock
`timescale 1ns/1ps
module pat_arbiter_tb;
  import pat_pkg::*;
  logic              clk, rst, miso, sck, ss_n, mosi, cks, sd, roam, dv, rs, av, mv, skip, stop;
  logic [PKT_W-1:0]  part_w, stat_w, sd_w, roam_w, dw, rx;
  logic [ADDR_W-1:0] aa;
  logic [1:0]        ae;
  logic [MASK_W-1:0] mask;
  logic [3:0]        midx;
  logic [5:0]        lvl;
  int                err_total, cmp_count, cyc, n;
  localparam logic [20:0] A0 = 21'h0a5a5a, AN = 21'h155555, AF = 21'h1f00f1, A3 = 21'h033333, AL = 21'h0c3c3c;

  pat_arbiter u_dut (.CLOCK_I(clk), .RST_I(rst), .SPI_SCK_I(sck), .SPI_SS_N_I(ss_n),
    .SPI_MOSI_I(mosi), .SPI_MISO_O(miso), .CHECKSUM_DIS_I(cks), .PART_ID_WORD_I(part_w),
    .STATUS_WORD_I(stat_w), .SHUTDOWN_REQ_I(sd), .SHUTDOWN_WORD_I(sd_w), .ROAM_REQ_I(roam),
    .ROAM_WORD_I(roam_w), .DATA_VALID_I(dv), .DATA_WORD_I(dw), .DECODE_RESTART_I(rs),
    .RX_ADDR_VALID_I(av), .RX_ADDR_I(aa), .RX_ADDR_ERRS_I(ae), .ENABLE_MASK_O(mask),
    .MATCH_VALID_O(mv), .MATCH_INDEX_O(midx), .SKIP_VECTOR_O(skip), .DECODE_STOP_O(stop),
    .BUF_LEVEL_O(lvl));
  pat_host_model u_host (.sck_o(sck), .ss_n_o(ss_n), .mosi_o(mosi), .miso_i(miso));

  // 200 MHz core clock
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // hang guard, far beyond the nineteen frames of the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // inputs move 1 ns after the core edge
  task automatic tk(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic send(input logic [31:0] tx);
    u_host.xfer(tx, rx);
    tk(1);
  endtask

  // id 0 is not a command here, so the word sent by a read has no side effect
  task automatic rd(input logic [31:0] exp);
    tk(4);
    send(32'h00000000);
    cmp(rx, exp);
  endtask

  task automatic asg(input logic [3:0] i, input logic [1:0] lt, input logic [20:0] a);
    send({ID_ASSIGN_HI, i, 1'h0, lt, a});
  endtask

  task automatic msk(input logic [15:0] m);
    send({ID_ENABLE_MASK, 8'h00, m});
    cmp(32'(mask), 32'(m));
  endtask

  task automatic hit(input logic [20:0] a, input logic [1:0] e, input logic v, input logic [3:0] i,
                     input logic s);
    tk(1);
    av = 1'h1;
    aa = a;
    ae = e;
    tk(1);
    av = 1'h0;
    cmp(32'({mv, skip}), 32'({v, s}));
    if (v) cmp(32'(midx), 32'(i));
  endtask

  // main sequence
  initial begin
    {rst, cks, sd, roam, dv, rs, av, aa, ae} = '0;
    rst = 1'h1;
    part_w = 32'h5a5a0001; // arbitrary part code
    stat_w = 32'h0f0f0f0f;
    sd_w = 32'h1a000011;
    roam_w = 32'h1c000022;
    dw = 32'h00abcdef;
    tk(16);
    rst = 1'h0;
    tk(8);
    cmp(32'({mask, lvl}), 32'h0);
    asg(4'h0, 2'h0, A0);
    asg(4'hf, 2'h1, AF);
    asg(4'h3, 2'h0, A3);
    msk(16'h8001);
    hit(A0, 2'h2, 1'h1, 4'h0, 1'h0);
    hit(AF, 2'h0, 1'h1, 4'hf, 1'h1);
    hit(A3, 2'h0, 1'h0, 4'h0, 1'h0);
    hit(A0, 2'h3, 1'h0, 4'h0, 1'h0);
    cmp(32'(lvl), 32'h2);
    sd = 1'h1;
    roam = 1'h1;
    tk(1);
    sd = 1'h0;
    roam = 1'h0;
    rd(sd_w);
    rd(roam_w);
    rd(32'h01000000);
    rd(32'h01000f00);
    rd(stat_w);
    cks = 1'h1;
    rd(part_w);
    cks = 1'h0;
    msk(16'h8000);
    asg(4'h0, 2'h0, AN);
    msk(16'h8001);
    hit(AN, 2'h0, 1'h1, 4'h0, 1'h0);
    hit(A0, 2'h0, 1'h0, 4'h0, 1'h0);
    hit(AF, 2'h1, 1'h1, 4'hf, 1'h1);
    // fill from two entries until the buffer overflows
    for (n = 0; n < 40 && stop !== 1'h1; n++) begin
      dv = 1'h1;
      tk(1);
      dv = 1'h0;
      tk(1);
    end
    cmp(32'(n), 32'd31);
    cmp(32'({stop, lvl}), 32'h40);
    hit(AN, 2'h0, 1'h0, 4'h0, 1'h0);
    rs = 1'h1;
    tk(1);
    rs = 1'h0;
    tk(1);
    cmp(32'(stop), 32'h0);
    dv = 1'h1;
    tk(1);
    dv = 1'h0;
    rd(dw);
    // long pair at words 4 and 5, both tone-only; word 3 holds the same value but stays disabled
    asg(4'h4, 2'h3, A3);
    asg(4'h5, 2'h3, AL);
    msk(16'h8031);
    hit(A3, 2'h0, 1'h1, 4'h4, 1'h1);
    hit(AL, 2'h1, 1'h1, 4'h5, 1'h1);
    rd(32'h01100400);
    rd(32'h01100500);
    end_sim();
  end
endmodule
